//--- spc_defines.svh
// Register offsets, field positions, reset values and the failed-trial limit for the port CSR block
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

`define SPC_ADDR_W          16
`define SPC_OFS_ERR_STAT    16'hB158
`define SPC_OFS_CTL         16'hB15C
`define SPC_OFS_ERR_BH      16'hC000

// Error and status fields
`define SPC_ES_OUT_FAILED   25
`define SPC_ES_IN_ERR_ENC   9
`define SPC_ES_IN_ERR_STP   8
`define SPC_ES_PW_PEND      4
`define SPC_ES_UNAVAIL      3
`define SPC_ES_PORT_ERR     2
`define SPC_ES_PORT_OK      1
`define SPC_ES_UNINIT       0

// Control fields
`define SPC_CT_DISABLE      23
`define SPC_CT_OUT_EN       22
`define SPC_CT_IN_EN        21
`define SPC_CT_ERR_CHK_DIS  20
`define SPC_CT_MCAST        19
`define SPC_CT_FLOW_CTRL    18
`define SPC_CT_ENUM_B       17
`define SPC_CT_FLOW_ARB     16
`define SPC_CT_STOP_FAIL    3
`define SPC_CT_DROP_EN      2
`define SPC_CT_LOCKOUT      1
`define SPC_CT_PORT_TYPE    0

// Width codes
`define SPC_IW_LANE0        3'h0
`define SPC_IW_LANE2        3'h1
`define SPC_IW_FOUR         3'h2
`define SPC_OVR_NONE        3'h0
`define SPC_OVR_LANE0       3'h2
`define SPC_OVR_LANE2       3'h3

// Header constants
`define SPC_NEXT_PTR        16'h0000
`define SPC_FEAT_ID         16'h0007

// Fatal error after this many consecutive failed link-request trials
`define SPC_LREQ_LIMIT      3'h4
`define SPC_UNINIT_RESET    1'h1
`define SPC_SERIAL_TYPE     1'h1

`endif

//--- spc_pkg.sv
// Types shared by the port CSR block
package spc_pkg;
    // Link-side status events and levels into the register block
    typedef struct packed {
        logic       in_err_stopped;
        logic       init_done;
        logic       sym_ok;
        logic       merged;
        logic       pw_request;
        logic       lreq_fail;
        logic       lreq_good;
        logic       failed_thresh;
        logic [2:0] init_width;
        logic [1:0] width_support;
    } spc_link_type;

    // Port controls steering the datapath
    typedef struct packed {
        logic       rx_on;
        logic       tx_on;
        logic       tx_maint_only;
        logic       rx_maint_only;
        logic       err_chk_off;
        logic       mcast_fwd;
        logic       flow_ctrl;
        logic       enum_bound;
        logic       flow_arb;
        logic       drop_pkts;
        logic       stop_pkts;
        logic       lockout;
        logic [2:0] width_ovr;
    } spc_ctl_type;

    typedef enum logic [1:0] {
        SPC_UNINIT,
        SPC_OK,
        SPC_ERRSTOP
    } spc_link_st_type;
endpackage

//--- spc_sync.sv
// Two-flop synchroniser for a group of pin-level inputs
`timescale 1ns/1ps
`include "spc_defines.svh"
module spc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and control
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic             enable_i,
    // Data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clock_i) begin
                if (reset_i) begin
                    stage1[g] <= 1'b0;
                    sync_o[g] <= 1'b0;
                end else if (enable_i) begin
                    stage1[g] <= async_i[g];
                    sync_o[g] <= stage1[g];
                end
            end
        end
    endgenerate
endmodule

//--- spc_fail_cnt.sv
// Consecutive failed link-request counter raising a fatal event
`timescale 1ns/1ps
`include "spc_defines.svh"
module spc_fail_cnt (
    // Clock and control
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic enable_i,
    // Trial outcomes
    input  wire logic fail_i,
    input  wire logic good_i,
    output logic      fatal_o
);
    logic [2:0] count;
    wire  [2:0] next_count = (count == `SPC_LREQ_LIMIT) ? 3'h1 : count + 3'h1;
    wire        hit        = fail_i && (next_count == `SPC_LREQ_LIMIT);

    // Count failed trials; a good response restarts the run
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            count   <= 3'h0;
            fatal_o <= 1'b0;
        end else if (enable_i) begin
            fatal_o <= hit;
            if (good_i) begin
                count <= 3'h0;
            end else if (fail_i) begin
                count <= next_count;
            end
        end
    end
endmodule

//--- spc_port_csr.sv
// Port control and error-status registers with the error block header
// How it works
// - Input error-encountered sets whenever input error-stopped rises; write 1 clears.
// - Bit 8 reads high exactly while input is error-stopped.
// - Port-write pending bit 4 sets on a port-write need; write 1 clears.
// - Bit 3 shows the port lanes merged into another port.
// - Four consecutive failed link-request trials set fatal port error bit 2.
// - Bit 1 high while initialized, exchanging clean control symbols and port disable bit 23 is clear.
// - Bit 0 high while uninitialized, resets to 1, never with port OK.
// - Three-bit initialized width field reports lane 0, lane 2 or four lanes.
// - Three-bit width override: none, force lane 0, force lane 2.
// - Port disable bit 23 turns receivers and drivers off.
// - Output enable low sends only maintenance packets; symbols still go.
// - Input enable low accepts maintenance only, others refused.
// - Bit 20 turns off error checking and recovery.
// - Multicast-event symbols forwarded only while bit 19 is set.
// - Read-write flow control, enumeration boundary, flow arbitration bits, reset 0.
// - Stop-on-failed with output failed sets port error and stops packets.
// - Drop enable with failed threshold discards refused packets until healed.
// - Lockout stops packets both ways, refuses received ones, keeps training.
// - Port type bit 0 reads 1, a serial port.
// - Bits 31-30 report 4x and 2x support from path configuration.
// - Extended width fields at 15-14 and 13-12 are read-only zero.
// - Header reads next pointer 0x0000 and feature identifier 0x0007.
// - Output failed-encountered bit 25 sets at failed threshold; write 1 clears.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "spc_defines.svh"
module spc_port_csr (
    // Clock, reset, enable
    input  wire logic                       clock_i,
    input  wire logic                       reset_i,
    input  wire logic                       enable_i,
    // Register port
    input  wire logic [`SPC_ADDR_W-1:0]     addr_i,
    input  wire logic [31:0]                wdata_i,
    input  wire logic                       write_i,
    input  wire logic                       read_i,
    output logic      [31:0]                rdata_o,
    // Link-side status from pins
    input  wire spc_pkg::spc_link_type      link_i,
    // Port controls
    output spc_pkg::spc_ctl_type            ctl_o,
    output logic                            pw_pending_o,
    output logic                            fatal_o
);
    // Assertion clock and reset
    default clocking chk_clk @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    // Control register fields
    logic [2:0] width_ovr;
    logic       port_dis;
    logic       out_en;
    logic       in_en;
    logic       err_chk_dis;
    logic       mcast;
    logic       flow_ctrl;
    logic       enum_b;
    logic       flow_arb;
    logic       stop_fail;
    logic       drop_en;
    logic       lockout;
    // Sticky flags and edge-detect delays
    logic       out_failed;
    logic       in_err_enc;
    logic       pw_pend;
    logic       port_err;
    logic       in_stp_d;
    logic       failed_d;

    // Synchronised link status
    spc_pkg::spc_link_type  lk;
    spc_pkg::spc_link_st_type link_st;
    logic [$bits(spc_pkg::spc_link_type)-1:0] lk_flat;
    logic        fatal_ev;

    spc_sync #(
        .WIDTH ($bits(spc_pkg::spc_link_type))
    ) u_sync (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .enable_i (enable_i),
        .async_i  (link_i),
        .sync_o   (lk_flat)
    );
    assign lk = spc_pkg::spc_link_type'(lk_flat);

    // Fatal-error trial counter, gated off when checking is disabled
    spc_fail_cnt u_fail (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .enable_i (enable_i),
        .fail_i   (lk.lreq_fail && !err_chk_dis),
        .good_i   (lk.lreq_good),
        .fatal_o  (fatal_ev)
    );

    // Decode
    wire hit_stat = (addr_i == `SPC_OFS_ERR_STAT);
    wire hit_ctl  = (addr_i == `SPC_OFS_CTL);
    wire hit_bh   = (addr_i == `SPC_OFS_ERR_BH);
    wire wr_stat  = write_i && hit_stat;
    wire wr_ctl   = write_i && hit_ctl;

    // Events that set sticky flags
    wire in_stp_rise  = lk.in_err_stopped && !in_stp_d;
    wire failed_rise  = lk.failed_thresh && !failed_d;
    wire stop_fatal   = stop_fail && failed_rise;
    wire set_port_err = fatal_ev || stop_fatal;
    wire clr_of  = wr_stat && wdata_i[`SPC_ES_OUT_FAILED];
    wire clr_ie  = wr_stat && wdata_i[`SPC_ES_IN_ERR_ENC];
    wire clr_pw  = wr_stat && wdata_i[`SPC_ES_PW_PEND];
    wire clr_pe  = wr_stat && wdata_i[`SPC_ES_PORT_ERR];

    // Link state view
    wire port_ok  = lk.init_done && lk.sym_ok && !port_dis;
    assign link_st = !lk.init_done ? spc_pkg::SPC_UNINIT :
                     lk.in_err_stopped ? spc_pkg::SPC_ERRSTOP : spc_pkg::SPC_OK;

    // Status and control read words
    wire [31:0] stat_word = {6'h00, out_failed, 15'h0000,
                             in_err_enc, lk.in_err_stopped,
                             3'h0, pw_pend, lk.merged,
                             port_err, port_ok,
                             (link_st == spc_pkg::SPC_UNINIT)};
    wire [31:0] ctl_word  = {lk.width_support,
                             lk.init_done ? lk.init_width : `SPC_IW_LANE0,
                             width_ovr, port_dis, out_en, in_en,
                             err_chk_dis, mcast, flow_ctrl, enum_b, flow_arb,
                             4'h0,
                             8'h00, stop_fail, drop_en, lockout,
                             `SPC_SERIAL_TYPE};
    wire [31:0] bh_word   = {`SPC_NEXT_PTR, `SPC_FEAT_ID};
    wire [31:0] next_rdata = !read_i  ? 32'h0000_0000 :
                             hit_stat ? stat_word :
                             hit_ctl  ? ctl_word :
                             hit_bh   ? bh_word : 32'h0000_0000;

    // Width override accepts only defined codes
    wire ovr_ok = (wdata_i[26:24] == `SPC_OVR_NONE) ||
                  (wdata_i[26:24] == `SPC_OVR_LANE0) ||
                  (wdata_i[26:24] == `SPC_OVR_LANE2);

    // Control register writes
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            width_ovr   <= `SPC_OVR_NONE;
            port_dis    <= 1'b0;
            out_en      <= 1'b0;
            in_en       <= 1'b0;
            err_chk_dis <= 1'b0;
            mcast       <= 1'b0;
            {flow_ctrl, enum_b, flow_arb} <= 3'h0;
            {stop_fail, drop_en, lockout} <= 3'h0;
        end else if (enable_i && wr_ctl) begin
            if (ovr_ok) begin
                width_ovr <= wdata_i[26:24];
            end
            port_dis    <= wdata_i[`SPC_CT_DISABLE];
            out_en      <= wdata_i[`SPC_CT_OUT_EN];
            in_en       <= wdata_i[`SPC_CT_IN_EN];
            err_chk_dis <= wdata_i[`SPC_CT_ERR_CHK_DIS];
            mcast       <= wdata_i[`SPC_CT_MCAST];
            flow_ctrl   <= wdata_i[`SPC_CT_FLOW_CTRL];
            enum_b      <= wdata_i[`SPC_CT_ENUM_B];
            flow_arb    <= wdata_i[`SPC_CT_FLOW_ARB];
            stop_fail   <= wdata_i[`SPC_CT_STOP_FAIL];
            drop_en     <= wdata_i[`SPC_CT_DROP_EN];
            lockout     <= wdata_i[`SPC_CT_LOCKOUT];
        end
    end

    // Sticky flags: set wins over a clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            out_failed <= 1'b0;
            in_err_enc <= 1'b0;
            pw_pend    <= 1'b0;
            port_err   <= 1'b0;
            in_stp_d   <= 1'b0;
            failed_d   <= 1'b0;
        end else if (enable_i) begin
            in_stp_d   <= lk.in_err_stopped;
            failed_d   <= lk.failed_thresh;
            out_failed <= failed_rise || (out_failed && !clr_of);
            in_err_enc <= in_stp_rise || (in_err_enc && !clr_ie);
            pw_pend    <= lk.pw_request || (pw_pend && !clr_pw);
            port_err   <= set_port_err || (port_err && !clr_pe);
        end
    end

    // Datapath controls and read data
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_o      <= 32'h0000_0000;
            ctl_o        <= '0;
            pw_pending_o <= 1'b0;
            fatal_o      <= 1'b0;
        end else if (enable_i) begin
            rdata_o             <= next_rdata;
            ctl_o.rx_on         <= !port_dis;
            ctl_o.tx_on         <= !port_dis;
            ctl_o.tx_maint_only <= !out_en || lockout;
            ctl_o.rx_maint_only <= !in_en || lockout;
            ctl_o.err_chk_off   <= err_chk_dis;
            ctl_o.mcast_fwd     <= mcast && !port_dis;
            ctl_o.flow_ctrl     <= flow_ctrl;
            ctl_o.enum_bound    <= enum_b;
            ctl_o.flow_arb      <= flow_arb;
            ctl_o.drop_pkts     <= drop_en && lk.failed_thresh;
            ctl_o.stop_pkts     <= stop_fail && (out_failed || failed_rise);
            ctl_o.lockout       <= lockout;
            ctl_o.width_ovr     <= width_ovr;
            pw_pending_o        <= pw_pend;
            fatal_o             <= port_err;
        end
    end

    // Checks
    AST_EXCL: assert property (@(posedge clock_i) disable iff (reset_i)
        !(stat_word[`SPC_ES_UNINIT] && stat_word[`SPC_ES_PORT_OK]))
        else $error("uninitialized and port OK both set");
    AST_IN_ENC: assert property (@(posedge clock_i) disable iff (reset_i)
        enable_i && in_stp_rise |=> in_err_enc)
        else $error("input error-encountered not set");
    AST_STICKY: assert property (@(posedge clock_i) disable iff (reset_i)
        enable_i && in_err_enc && !(wr_stat && wdata_i[9]) |=> in_err_enc)
        else $error("sticky flag lost without a clear");
    AST_PW: assert property (@(posedge clock_i) disable iff (reset_i)
        enable_i && lk.pw_request |=> pw_pend)
        else $error("port-write pending not set");
    AST_FATAL: assert property (@(posedge clock_i) disable iff (reset_i)
        enable_i && fatal_ev |=> port_err)
        else $error("fatal error not latched");
    AST_FAILED: assert property (@(posedge clock_i) disable iff (reset_i)
        enable_i && failed_rise |=> out_failed)
        else $error("output failed not latched");
    AST_BH: assert property (@(posedge clock_i) disable iff (reset_i)
        enable_i && read_i && hit_bh |=> rdata_o == 32'h0000_0007)
        else $error("header reads wrong");
    AST_DIS: assert property (@(posedge clock_i) disable iff (reset_i)
        enable_i && port_dis ##1 enable_i |-> !ctl_o.rx_on && !ctl_o.tx_on)
        else $error("disabled port still on");
    AST_TYPE: assert property (@(posedge clock_i) disable iff (reset_i)
        enable_i && read_i && hit_ctl |=> rdata_o[0])
        else $error("port type not serial");

    // Status read view
    AST_IN_STP: assert property (
        enable_i && read_i && hit_stat |=> rdata_o[8] == $past(lk.in_err_stopped))
        else $error("error-stopped reads wrong");

    AST_UNAVL: assert property (
        enable_i && read_i && hit_stat |=> rdata_o[3] == $past(lk.merged))
        else $error("unavailable reads wrong");

    AST_OK: assert property (
        enable_i && read_i && hit_stat |=> rdata_o[1] == $past(lk.init_done && lk.sym_ok && !port_dis))
        else $error("port OK reads wrong");

    AST_UNINIT: assert property (
        enable_i && read_i && hit_stat |=> rdata_o[0] == $past(!lk.init_done))
        else $error("uninitialized reads wrong");

    AST_IW: assert property (
        enable_i && read_i && hit_ctl |=>
        rdata_o[29:27] == $past(lk.init_done ? lk.init_width : 3'h0))
        else $error("initialized width reads wrong");

    AST_SUP: assert property (
        enable_i && read_i && hit_ctl |=> rdata_o[31:30] == $past(lk.width_support))
        else $error("width support reads wrong");

    AST_WIDE: assert property (
        enable_i && read_i && hit_ctl |=> rdata_o[15:12] == 4'h0)
        else $error("extended width not zero");

    // Control register and outputs
    AST_OVR_KEEP: assert property (
        enable_i && wr_ctl && !ovr_ok |=> $stable(width_ovr))
        else $error("reserved override taken");

    AST_OVR_TAKE: assert property (
        enable_i && wr_ctl && ovr_ok |=> width_ovr == $past(wdata_i[26:24]))
        else $error("override not taken");

    AST_RXON: assert property (
        enable_i && !port_dis |=> ctl_o.rx_on && ctl_o.tx_on)
        else $error("enabled port off");

    AST_TXM: assert property (
        enable_i && !out_en |=> ctl_o.tx_maint_only)
        else $error("output not limited");

    AST_RXM: assert property (
        enable_i && !in_en |=> ctl_o.rx_maint_only)
        else $error("input not limited");

    AST_CHKOFF: assert property (
        enable_i |=> ctl_o.err_chk_off == $past(err_chk_dis))
        else $error("check disable wrong");

    AST_MCAST: assert property (
        enable_i |=> ctl_o.mcast_fwd == $past(mcast && !port_dis))
        else $error("multicast forward wrong");

    AST_FLOW: assert property (
        enable_i |=>
        {ctl_o.flow_ctrl, ctl_o.enum_bound, ctl_o.flow_arb} == $past({flow_ctrl, enum_b, flow_arb}))
        else $error("flow bits wrong");

    AST_STOP: assert property (
        enable_i && stop_fatal |=> port_err && ctl_o.stop_pkts)
        else $error("stop on failed missed");

    AST_DROP: assert property (
        enable_i |=> ctl_o.drop_pkts == $past(drop_en && lk.failed_thresh))
        else $error("drop wrong");

    AST_LOCK: assert property (
        enable_i && lockout |=> ctl_o.lockout && ctl_o.tx_maint_only && ctl_o.rx_maint_only)
        else $error("lockout not applied");

    // Flags, copies and reset
    AST_CLR_PW: assert property (
        enable_i && clr_pw && !lk.pw_request |=> !pw_pend)
        else $error("port-write not cleared");

    AST_PE_KEEP: assert property (
        enable_i && port_err && !clr_pe |=> port_err)
        else $error("port error lost");

    AST_OUTS: assert property (
        enable_i |=> pw_pending_o == $past(pw_pend) && fatal_o == $past(port_err))
        else $error("flag copies wrong");

    AST_RST: assert property (
        disable iff (1'b0) reset_i |=> ctl_o == '0 && width_ovr == 3'h0 && !port_err && !pw_pend)
        else $error("reset values wrong");

    COV_LOCK:  cover property (ctl_o.lockout && ctl_o.rx_on);
    COV_OVR:   cover property (wr_ctl && !ovr_ok);
    COV_FATAL: cover property (@(posedge clock_i) fatal_ev ##1 clr_pe);
    COV_STOP:  cover property (@(posedge clock_i) stop_fatal);
    COV_OK:    cover property (@(posedge clock_i) port_ok ##1 lk.in_err_stopped);
endmodule

//--- spc_link_model.sv
// Link-partner model driving the port's link-side status lines
`timescale 1ns/1ps
module spc_link_model (
    // Clock
    input  wire logic             clock_i,
    // Status toward the port
    output spc_pkg::spc_link_type link_o
);
    // Quiet link at time zero
    initial link_o = '0;

    // One link-request trial outcome, one cycle wide, then a quiet gap
    task automatic trial(input logic fail);
        @(posedge clock_i);
        link_o.lreq_fail <= fail;
        link_o.lreq_good <= ~fail;
        @(posedge clock_i);
        link_o.lreq_fail <= 1'b0;
        link_o.lreq_good <= 1'b0;
        repeat (2) @(posedge clock_i);
    endtask

    // Single-cycle port-write need
    task automatic pulse_pw();
        @(posedge clock_i);
        link_o.pw_request <= 1'b1;
        @(posedge clock_i);
        link_o.pw_request <= 1'b0;
    endtask

    // Link state levels, held long enough to pass the synchroniser
    task automatic set_state(input logic init, input logic ok, input logic stop,
                             input logic merge, input logic thr, input logic [2:0] w,
                             input logic [1:0] sup);
        @(posedge clock_i);
        link_o.init_done      <= init;
        link_o.sym_ok         <= ok;
        link_o.in_err_stopped <= stop;
        link_o.merged         <= merge;
        link_o.failed_thresh  <= thr;
        link_o.init_width     <= w;
        link_o.width_support  <= sup;
        repeat (4) @(posedge clock_i);
    endtask
endmodule

//--- serial_port_ctl_err_csr_tb.sv
// Self-checking bench for the port control and error-status registers
`timescale 1ns/1ps
`include "spc_defines.svh"
module serial_port_ctl_err_csr_tb;
    localparam logic [31:0] wmask    = 32'h00FF000E;
    localparam logic [15:0] stat_adr = `SPC_OFS_ERR_STAT;
    logic                  clock_i  = 1'b0;
    logic                  reset_i  = 1'b1;
    logic                  enable_i = 1'b1;
    logic [15:0]           addr_i   = 16'h0000;
    logic [31:0]           wdata_i  = 32'h0;
    logic                  write_i  = 1'b0;
    logic                  read_i   = 1'b0;
    logic [31:0]           rdata_o;
    spc_pkg::spc_link_type lk;
    spc_pkg::spc_ctl_type  ctl_o;
    logic                  pw_pending_o;
    logic                  fatal_o;
    logic [31:0]           sh_ctl = 32'h0;
    logic [31:0]           sh_stk = 32'h0;
    logic [31:0]           d;
    int                    bad_count = 0;
    int                    n_checks = 0;

    // 100 MHz clock
    always #5 clock_i = ~clock_i;

    spc_link_model i_link (
        .clock_i (clock_i),
        .link_o  (lk)
    );

    spc_port_csr i_dut (
        .clock_i      (clock_i),
        .reset_i      (reset_i),
        .enable_i     (enable_i),
        .addr_i       (addr_i),
        .wdata_i      (wdata_i),
        .write_i      (write_i),
        .read_i       (read_i),
        .rdata_o      (rdata_o),
        .link_i       (lk),
        .ctl_o        (ctl_o),
        .pw_pending_o (pw_pending_o),
        .fatal_o      (fatal_o)
    );

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Single-cycle register write
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= v;
        write_i <= 1'b1;
        @(posedge clock_i);
        write_i <= 1'b0;
    endtask

    // Single-cycle read, data sampled in the following cycle
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask

    // Expected status word from the sticky shadow and the partner levels
    function automatic logic [31:0] exp_stat();
        logic [31:0] s;
        s = sh_stk;
        s[8] = lk.in_err_stopped;
        s[3] = lk.merged;
        s[1] = lk.init_done & lk.sym_ok & ~sh_ctl[23];
        s[0] = ~lk.init_done;
        return s;
    endfunction

    // Expected control word
    function automatic logic [31:0] exp_ctl();
        logic [31:0] c;
        c = sh_ctl;
        c[31:30] = lk.width_support;
        c[29:27] = lk.init_done ? lk.init_width : 3'h0;
        c[0] = 1'b1;
        return c;
    endfunction

    // Control write with shadow update; reserved override codes are ignored
    task automatic ctl_wr(input logic [31:0] v);
        sh_ctl = (sh_ctl & ~wmask) | (v & wmask);
        if (v[26:24] inside {3'h0, 3'h2, 3'h3}) begin
            sh_ctl[26:24] = v[26:24];
        end
        wr(`SPC_OFS_CTL, v);
    endtask

    // Control readback and the control outputs it steers
    task automatic ctl_chk();
        logic [31:0] c;
        c = sh_ctl;
        rd_chk(`SPC_OFS_CTL, exp_ctl());
        check({19'h0, ctl_o.rx_on, ctl_o.tx_on, ctl_o.tx_maint_only,
               ctl_o.rx_maint_only, ctl_o.flow_ctrl, ctl_o.enum_bound, ctl_o.flow_arb,
               ctl_o.err_chk_off, ctl_o.lockout, ctl_o.mcast_fwd, ctl_o.width_ovr},
              {19'h0, ~c[23], ~c[23], ~c[22] | c[1], ~c[21] | c[1],
               c[18], c[17], c[16], c[20], c[1], c[19] & ~c[23], c[26:24]});
    endtask

    // Counts, verdict and end of run
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        end_of_test();
    end

    // Main sequence
    initial begin
        void'($urandom(98));
        repeat (5) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rd_chk(stat_adr, exp_stat());
        ctl_chk();
        rd_chk(`SPC_OFS_ERR_BH, 32'h00000007);
        rd_chk(16'h0100, 32'h0);
        // Random control words, every override code twice
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            d[26:24] = i[2:0];
            ctl_wr(d);
            ctl_chk();
        end
        ctl_wr(32'h0);
        // Link up at four lanes, then port disabled
        i_link.set_state(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h2, 2'h2);
        rd_chk(stat_adr, exp_stat());
        ctl_chk();
        ctl_wr(32'h00800000);
        rd_chk(stat_adr, exp_stat());
        ctl_wr(32'h0);
        // Input error-stopped sets the sticky flag; only a 1 clears it
        i_link.set_state(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h2, 2'h2);
        sh_stk[9] = 1'b1;
        rd_chk(stat_adr, exp_stat());
        i_link.set_state(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h2, 2'h2);
        wr(stat_adr, 32'hFFFFFDFF);
        rd_chk(stat_adr, exp_stat());
        wr(stat_adr, 32'h00000200);
        sh_stk[9] = 1'b0;
        rd_chk(stat_adr, exp_stat());
        // Port-write need
        i_link.pulse_pw();
        repeat (4) @(posedge clock_i);
        sh_stk[4] = 1'b1;
        rd_chk(stat_adr, exp_stat());
        check({31'h0, pw_pending_o}, 32'h1);
        wr(stat_adr, 32'h00000010);
        sh_stk[4] = 1'b0;
        rd_chk(stat_adr, exp_stat());
        // Lanes merged into another port
        i_link.set_state(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 3'h1, 2'h1);
        rd_chk(stat_adr, exp_stat());
        i_link.set_state(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h1, 2'h1);
        // Three fails, a good trial, three fails: no fatal yet
        for (int i = 0; i < 7; i++) begin
            i_link.trial(i != 3);
        end
        repeat (4) @(posedge clock_i);
        rd_chk(stat_adr, exp_stat());
        i_link.trial(1'b1);
        repeat (4) @(posedge clock_i);
        sh_stk[2] = 1'b1;
        rd_chk(stat_adr, exp_stat());
        check({31'h0, fatal_o}, 32'h1);
        wr(stat_adr, 32'h00000004);
        sh_stk[2] = 1'b0;
        rd_chk(stat_adr, exp_stat());
        // Failed threshold with stop and drop enabled
        ctl_wr(32'h0000000C);
        i_link.set_state(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h1, 2'h1);
        sh_stk[25] = 1'b1;
        sh_stk[2] = 1'b1;
        rd_chk(stat_adr, exp_stat());
        check({31'h0, fatal_o}, 32'h1);
        check({30'h0, ctl_o.drop_pkts, ctl_o.stop_pkts}, 32'h3);
        wr(stat_adr, 32'h02000004);
        sh_stk = 32'h0;
        rd_chk(stat_adr, exp_stat());
        // A write while the clock enable is low is lost
        enable_i <= 1'b0;
        wr(`SPC_OFS_CTL, 32'h00FF000E);
        enable_i <= 1'b1;
        ctl_chk();
        // Reset in mid-run returns the controls
        i_link.set_state(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 2'h0);
        ctl_wr(32'h00FF000E);
        @(posedge clock_i);
        reset_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        sh_ctl = 32'h0;
        repeat (3) @(posedge clock_i);
        ctl_chk();
        rd_chk(stat_adr, exp_stat());
        end_of_test();
    end
endmodule
